// ### shared/scg_consts.svh
`ifndef SCG_CONSTS_SVH
`define SCG_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define SCG_OFF_ALT     8'h00
`define SCG_OFF_DOUT    8'h04
`define SCG_OFF_DOE     8'h08
`define SCG_OFF_GPIN    8'h0c
`define SCG_OFF_DSR     8'h10
`define SCG_OFF_STRAP   8'h14
`define SCG_OFF_XINT    8'h18

// ==========================================================
// Field layout and reset values
`define SCG_ALT_MASK    14'h27ff
`define SCG_ALT_RSTOUT  14'h0007
`define SCG_DSR_RST     3'h7
`define SCG_STRAP_REF   0
`define SCG_STRAP_SLOW  1
`define SCG_STRAP_CLK   2
`define SCG_STRAP_MRG   4
`define SCG_CAP_WAIT    2'h2
`define SCG_RESP_OKAY   2'h0
`define SCG_RESP_SLVERR 2'h2

// ==========================================================
// Timing
`define SCG_CLK_KHZ     250000
`define SCG_SMB_SLOW_KHZ 100
`define SCG_SMB_FAST_KHZ 400
`define SCG_SMB_SLOW_CYC (`SCG_CLK_KHZ / `SCG_SMB_SLOW_KHZ)
`define SCG_SMB_FAST_CYC (`SCG_CLK_KHZ / `SCG_SMB_FAST_KHZ)

`endif

// ### shared/scg_pkg.sv
package scg_pkg;

  // Link width of one port after the merge straps are applied.
  typedef enum logic [1:0] {
    SCG_W_OFF,
    SCG_W_X4,
    SCG_W_X8
  } scg_width_t;

  // Whole state of the strap and pin mux block.
  typedef struct packed {
    logic [13:0]               gs1;
    logic [13:0]               gs2;
    logic [6:0]                ss1;
    logic [6:0]                ss2;
    logic [1:0]                cap_cnt;
    logic                      cap_done;
    logic [6:0]                strap;
    logic [13:0]               alt;
    logic [13:0]               dout;
    logic [13:0]               doe;
    logic [2:0]                dsr;
    logic [13:0]               pin_o;
    logic [13:0]               pin_oe;
    logic [8:0]                xint;
    logic [11:0]               div;
    logic                      tick;
    scg_width_t [5:0]          width;
    logic                      aw_have;
    logic                      w_have;
    logic [7:0]                awaddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      awready;
    logic                      wready;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [1:0]                rresp;
    logic [31:0]               rdata;
  } scg_state_t;

endpackage : scg_pkg

// ### rtl/scg_strap_gpio.sv
// Contract
// R1: Pins 18 to 31 work as plain two-way GPIO when not in alternate use.
// R2: In alternate use pins 18, 19, 20 drive low-active resets of ports 13-15.
// R3: In alternate use pins 21 to 28 take expander interrupts 0 to 7.
// R4: Pin 31 may take expander interrupt 10; pins 29, 30 are GPIO only.
// R5: Refclk select 0 means 100 MHz and 1 means 125 MHz.
// R6: Slow strap set gives 100 kHz master SMBus, else 400 kHz, fixed.
// R7: Merge straps are low active, so an open strap means merged.
// R8: Pair 0/1 strap low merges into one x8, port 1 lanes become 4-7.
// R9: A pair whose merge strap is high runs as two x4 ports.
// R10: Pair 2/3 strap low merges into one x8, port 3 lanes become 4-7.
// R11: Pair 4/5 strap low merges into one x8, port 5 lanes become 4-7.
// R12: A two-bit strap selects the port clocking mode.
// R13: Straps are held through reset, captured after it, kept until next.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`include "scg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module scg_strap_gpio #(
  parameter int unsigned SMB_SLOW_CYC = `SCG_SMB_SLOW_CYC,
  parameter int unsigned SMB_FAST_CYC = `SCG_SMB_FAST_CYC
) (
  input  wire logic                aclk,       // System clock.
  input  wire logic                aresetn,    // Sync reset, low.
  input  wire logic [7:0]          awaddr,     // Write address.
  input  wire logic                awvalid,    // Write addr valid.
  output logic                     awready,    // Write addr ready.
  input  wire logic [31:0]         wdata,      // Write data.
  input  wire logic [3:0]          wstrb,      // Byte enables.
  input  wire logic                wvalid,     // Write data valid.
  output logic                     wready,     // Write data ready.
  output logic [1:0]               bresp,      // Write response.
  output logic                     bvalid,     // Response valid.
  input  wire logic                bready,     // Response ready.
  input  wire logic [7:0]          araddr,     // Read address.
  input  wire logic                arvalid,    // Read addr valid.
  output logic                     arready,    // Read addr ready.
  output logic [31:0]              rdata,      // Read data.
  output logic [1:0]               rresp,      // Read response.
  output logic                     rvalid,     // Read valid.
  input  wire logic                rready,     // Read ready.
  input  wire logic [31:18]        gpio_i,     // Pin levels in.
  output logic [31:18]             gpio_o,     // Pin drive levels.
  output logic [31:18]             gpio_oe,    // Pin drive enables.
  input  wire logic                refclk_frequency_select, // Strap.
  input  wire logic                master_smbus_slow_select, // Strap.
  input  wire logic [1:0]          port_clocking_select, // Strap.
  input  wire logic                pair01_merge_strap_n, // Strap.
  input  wire logic                pair23_merge_strap_n, // Strap.
  input  wire logic                pair45_merge_strap_n, // Strap.
  output logic [7:0]               expander_interrupt_in, // High = int.
  output logic                     expander_interrupt_in_high, // Int 10.
  output logic                     strap_valid, // Straps captured.
  output logic                     refclk_is_125, // Refclk is 125 MHz.
  output logic                     master_smbus_slow, // 100 kHz mode.
  output logic                     master_smbus_tick, // Bit-rate enable.
  output logic [1:0]               port_clock_mode, // Clocking mode.
  output scg_pkg::scg_width_t [5:0] port_width  // Width per port.
);

  // ========================================================
  // Parameter checks
  if (SMB_FAST_CYC < 2 || SMB_SLOW_CYC > 4096 ||
      SMB_FAST_CYC > SMB_SLOW_CYC)
  begin : g_bad_cyc
    $error("scg_strap_gpio: SMBus periods out of range.");
  end

  localparam logic [11:0] SLOW_LD = 12'(SMB_SLOW_CYC - 1);
  localparam logic [11:0] FAST_LD = 12'(SMB_FAST_CYC - 1);

  scg_pkg::scg_state_t q;
  scg_pkg::scg_state_t next_q;

  // ========================================================
  // Register read mux
  function automatic logic [32:0] rd_reg(
    input scg_pkg::scg_state_t s,
    input logic [7:0]          a
  );
    logic [32:0] r;
    r = 33'h0;
    case (a)
      `SCG_OFF_ALT:   r = {1'b1, 18'h0, s.alt};
      `SCG_OFF_DOUT:  r = {1'b1, 18'h0, s.dout};
      `SCG_OFF_DOE:   r = {1'b1, 18'h0, s.doe};
      `SCG_OFF_GPIN:  r = {1'b1, 18'h0, s.gs2};
      `SCG_OFF_DSR:   r = {1'b1, 29'h0, s.dsr};
      `SCG_OFF_STRAP: r = {1'b1, 24'h0, s.cap_done, s.strap};
      `SCG_OFF_XINT:  r = {1'b1, 23'h0, s.xint};
      default:        r = 33'h0;
    endcase
    return r;
  endfunction : rd_reg

  // ========================================================
  // Next-state logic
  always_comb
  begin
    logic [32:0] rv;
    logic [31:0] m;
    logic [31:0] v;
    logic        merged;
    rv = 33'h0;
    m = 32'h0;
    v = 32'h0;
    merged = 1'b0;
    next_q = q;

    // Two-flop synchronisers for pins and straps.
    next_q.gs1 = gpio_i;
    next_q.gs2 = q.gs1;
    next_q.ss1 = {pair45_merge_strap_n, pair23_merge_strap_n,
                  pair01_merge_strap_n, port_clocking_select,
                  master_smbus_slow_select, refclk_frequency_select};
    next_q.ss2 = q.ss1;

    // R13 strap capture
    // Capture once the synchronisers hold post-reset levels.
    if (!q.cap_done)
    begin
      if (q.cap_cnt == `SCG_CAP_WAIT)
      begin
        next_q.strap = q.ss2;
        next_q.cap_done = 1'b1;
      end
      else
        next_q.cap_cnt = q.cap_cnt + 2'h1;
    end

    // R1 plain GPIO
    // Pins not in alternate use follow the data and enable registers.
    next_q.pin_oe = (q.doe & ~q.alt) | (q.alt & `SCG_ALT_RSTOUT);
    // R2 reset outputs
    // Reset outputs drive low while their reset bit is set.
    next_q.pin_o = (q.dout & ~q.alt) | ({11'h0, ~q.dsr} & q.alt);

    // R3 expander interrupts
    // Low pin levels are reported as high interrupt flags.
    next_q.xint[7:0] = ~q.gs2[10:3] & q.alt[10:3];
    // R4 interrupt ten
    next_q.xint[8] = ~q.gs2[13] & q.alt[13];

    // R6 SMBus rate
    // Divider gives one tick per SMBus period, set only by the strap.
    if (!q.cap_done)
    begin
      next_q.div = 12'h0;
      next_q.tick = 1'b0;
    end
    else if (q.div == 12'h0)
    begin
      next_q.div = q.strap[`SCG_STRAP_SLOW] ? SLOW_LD : FAST_LD;
      next_q.tick = 1'b1;
    end
    else
    begin
      next_q.div = q.div - 12'h1;
      next_q.tick = 1'b0;
    end

    // R7 R8 R9 R10 R11 merge decode
    // Merged even port takes the odd port's lanes as lanes 4-7.
    for (int p = 0; p < 3; p++)
    begin
      merged = ~q.strap[`SCG_STRAP_MRG + p];
      if (!q.cap_done)
      begin
        next_q.width[2*p] = scg_pkg::SCG_W_OFF;
        next_q.width[2*p+1] = scg_pkg::SCG_W_OFF;
      end
      else if (merged)
      begin
        next_q.width[2*p] = scg_pkg::SCG_W_X8;
        next_q.width[2*p+1] = scg_pkg::SCG_W_OFF;
      end
      else
      begin
        next_q.width[2*p] = scg_pkg::SCG_W_X4;
        next_q.width[2*p+1] = scg_pkg::SCG_W_X4;
      end
    end

    // AXI write channels are taken independently.
    if (awvalid && q.awready)
    begin
      next_q.aw_have = 1'b1;
      next_q.awaddr = awaddr;
    end
    if (wvalid && q.wready)
    begin
      next_q.w_have = 1'b1;
      next_q.wdata = wdata;
      next_q.wstrb = wstrb;
    end
    if (q.bvalid && bready)
      next_q.bvalid = 1'b0;

    // Perform the write once address and data are both held.
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      rv = rd_reg(q, q.awaddr);
      m = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}},
           {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
      v = (rv[31:0] & ~m) | (q.wdata & m);
      next_q.aw_have = 1'b0;
      next_q.w_have = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = rv[32] ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
      case (q.awaddr)
        // R4 no alternate
        // Pins 29 and 30 cannot be put in alternate use.
        `SCG_OFF_ALT:  next_q.alt = v[13:0] & `SCG_ALT_MASK;
        `SCG_OFF_DOUT: next_q.dout = v[13:0];
        `SCG_OFF_DOE:  next_q.doe = v[13:0];
        `SCG_OFF_DSR:  next_q.dsr = v[2:0];
        default:       next_q.dsr = q.dsr;
      endcase
    end
    next_q.awready = !next_q.aw_have && !next_q.bvalid;
    next_q.wready = !next_q.w_have && !next_q.bvalid;

    // AXI read answers one cycle after the address is taken.
    if (q.rvalid && rready)
      next_q.rvalid = 1'b0;
    if (arvalid && q.arready)
    begin
      rv = rd_reg(q, araddr);
      next_q.rvalid = 1'b1;
      next_q.rdata = rv[31:0];
      next_q.rresp = rv[32] ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
    end
    next_q.arready = !next_q.rvalid;

    // Synchronous reset values.
    if (!aresetn)
    begin
      next_q = '0;
      next_q.dsr = `SCG_DSR_RST;
    end
  end

  // ========================================================
  // State register
  always_ff @(posedge aclk)
  begin
    q <= next_q;
  end

  // Outputs straight from state flops.
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign gpio_o = q.pin_o;
  assign gpio_oe = q.pin_oe;
  assign expander_interrupt_in = q.xint[7:0];
  assign expander_interrupt_in_high = q.xint[8];
  assign strap_valid = q.cap_done;
  // R5 refclk select
  assign refclk_is_125 = q.strap[`SCG_STRAP_REF];
  assign master_smbus_slow = q.strap[`SCG_STRAP_SLOW];
  assign master_smbus_tick = q.tick;
  // R12 clocking mode
  assign port_clock_mode = q.strap[`SCG_STRAP_CLK +: 2];
  assign port_width = q.width;

  // ========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [11:0] gap;
  always_ff @(posedge aclk)
  begin
    gap <= (!aresetn || master_smbus_tick) ? 12'h0 : gap + 12'h1;
  end

  gpio_plain_a: assert property ( // R1
    q.alt[11] == 1'b0 |=> gpio_oe[29] == $past(q.doe[11]))
    else $error("Plain pin enable not from register.");

  rst_out_a: assert property ( // R2
    q.alt[0] && q.dsr[0] |=> gpio_oe[18] && !gpio_o[18])
    else $error("Port 13 reset not driven low.");

  exp_int_a: assert property ( // R3
    q.alt[4] && !gpio_i[22] ##1 q.alt[4] ##1 q.alt[4]
    |=> expander_interrupt_in[1] && !gpio_oe[22])
    else $error("Expander interrupt 1 not seen.");

  no_alt_a: assert property (q.alt[12:11] == 2'h0) // R4
    else $error("Pins 29 or 30 in alternate use.");

  alt_in_a: assert property (q.alt[13] |=> !gpio_oe[31]) // R4
    else $error("Pin 31 driven in alternate use.");

  refclk_sel_a: assert property ( // R5
    $rose(strap_valid) |->
    refclk_is_125 == $past(refclk_frequency_select, 3))
    else $error("Refclk select mismatch.");

  smb_rate_a: assert property ( // R6
    master_smbus_tick && $past(strap_valid, 2) |->
    gap == (master_smbus_slow ? SLOW_LD : FAST_LD))
    else $error("SMBus tick spacing wrong.");

  merge01_a: assert property ( // R8
    $rose(strap_valid) && !q.strap[4] |=>
    port_width[0] == scg_pkg::SCG_W_X8 &&
    port_width[1] == scg_pkg::SCG_W_OFF)
    else $error("Pair 0/1 not merged.");

  split45_a: assert property ( // R9
    strap_valid && q.strap[6] |=>
    port_width[5:4] == {scg_pkg::SCG_W_X4, scg_pkg::SCG_W_X4})
    else $error("Pair 4/5 not split.");

  strap_hold_a: assert property ( // R13
    strap_valid |=> strap_valid && $stable(q.strap))
    else $error("Captured straps changed.");

  bresp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped.");

  write_cov_c: cover property (awvalid && awready ##[1:4] bvalid);
  read_cov_c: cover property (arvalid && arready ##1 rvalid);
  merge_cov_c: cover property (port_width[2] == scg_pkg::SCG_W_X8);
  tick_cov_c: cover property (master_smbus_tick && master_smbus_slow);

endmodule : scg_strap_gpio

`default_nettype wire

// ### tb/scg_board_model.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================================
// Board model: strap resistors and expander interrupt lines
module scg_board_model (
  input  wire logic [6:0]   strap_cfg, // Board strap setting.
  input  wire logic [8:0]   exp_n,     // Expander lines, low = pending.
  input  wire logic [31:18] gpio_o,    // Device drive level.
  input  wire logic [31:18] gpio_oe,   // Device drive enable.
  output logic [31:18]      gpio_i,    // Resolved pin levels.
  output logic              refclk_frequency_select,  // Strap.
  output logic              master_smbus_slow_select, // Strap.
  output logic [1:0]        port_clocking_select,     // Strap.
  output logic              pair01_merge_strap_n,     // Strap.
  output logic              pair23_merge_strap_n,     // Strap.
  output logic              pair45_merge_strap_n      // Strap.
);
  logic [31:18] ext;

  // strap levels held
  // Straps only move when the bench changes the setting; an open merge
  // strap is given as 0 since the internal pull-low is not in the logic.
  assign {pair45_merge_strap_n, pair23_merge_strap_n, pair01_merge_strap_n,
          port_clocking_select, master_smbus_slow_select,
          refclk_frequency_select} = strap_cfg;

  // open-drain expander lines
  // Expanders pull pins 21 to 28 and 31; the other pins have pull-ups.
  assign ext = {exp_n[8], 2'b11, exp_n[7:0], 3'b111};

  // wired pin level
  // A pin is low if the device drives it low or a board driver pulls it.
  assign gpio_i = ext & (gpio_o | ~gpio_oe);
endmodule : scg_board_model

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`include "scg_consts.svh"
`default_nettype none

module tb;
  localparam int SLOW = 20;
  localparam int FAST = 5;
  localparam logic [7:0] RA [4] = '{`SCG_OFF_ALT, `SCG_OFF_DOUT,
                                    `SCG_OFF_DOE, `SCG_OFF_DSR};

  logic                      aclk, aresetn;
  logic [7:0]                awaddr, araddr;
  logic                      awvalid, awready, wvalid, wready, bvalid;
  logic                      bready, arvalid, arready, rvalid, rready;
  logic [31:0]               wdata, rdata;
  logic [3:0]                wstrb;
  logic [1:0]                bresp, rresp, port_clocking_select;
  logic [1:0]                port_clock_mode;
  logic [31:18]              gpio_i, gpio_o, gpio_oe;
  logic                      refclk_frequency_select, master_smbus_slow_select;
  logic                      pair01_merge_strap_n, pair23_merge_strap_n;
  logic                      pair45_merge_strap_n, strap_valid, refclk_is_125;
  logic [7:0]                expander_interrupt_in;
  logic                      expander_interrupt_in_high, master_smbus_slow;
  logic                      master_smbus_tick;
  scg_pkg::scg_width_t [5:0] port_width;
  logic [6:0]                strap_cfg;
  logic [8:0]                exp_n;
  int                        num_errors, n_tests;

  scg_strap_gpio #(.SMB_SLOW_CYC(SLOW), .SMB_FAST_CYC(FAST)) dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .gpio_i, .gpio_o, .gpio_oe,
    .refclk_frequency_select, .master_smbus_slow_select,
    .port_clocking_select, .pair01_merge_strap_n, .pair23_merge_strap_n,
    .pair45_merge_strap_n, .expander_interrupt_in,
    .expander_interrupt_in_high, .strap_valid, .refclk_is_125,
    .master_smbus_slow, .master_smbus_tick, .port_clock_mode, .port_width);

  scg_board_model board_u (
    .strap_cfg, .exp_n, .gpio_o, .gpio_oe, .gpio_i, .refclk_frequency_select,
    .master_smbus_slow_select, .port_clocking_select, .pair01_merge_strap_n,
    .pair23_merge_strap_n, .pair45_merge_strap_n);

  // ========================================================
  // Clock, compare and bus tasks
  // Free-running 250 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Counts one compare and reports a mismatch.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One write; address and data are released as each is taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit wa, ww;
    wa = 0;
    ww = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(wa && ww))
    begin
      @(posedge aclk);
      if (awready === 1'b1) wa = 1;
      if (wready === 1'b1) ww = 1;
      if (wa) awvalid <= 1'b0;
      if (ww) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  // One read; the answer is taken at the edge where rvalid is seen.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  // Width a port must show for its pair's merge strap.
  function automatic scg_pkg::scg_width_t exp_w(input logic mn, input bit odd);
    if (mn) return scg_pkg::SCG_W_X4;
    return odd ? scg_pkg::SCG_W_OFF : scg_pkg::SCG_W_X8;
  endfunction : exp_w

  // ========================================================
  // Scenarios
  // Reset with a strap setting, then check what was captured.
  task automatic t_straps(input logic [6:0] cfg);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    strap_cfg <= cfg;
    aresetn   <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn   <= 1'b1;
    repeat (6) @(posedge aclk);
    check(strap_valid, 1'b1);
    check(refclk_is_125, cfg[0]);
    check(master_smbus_slow, cfg[1]);
    check(port_clock_mode, cfg[3:2]);
    for (int p = 0; p < 6; p++)
      check(port_width[p], exp_w(cfg[4 + p / 2], p[0]));
    do @(posedge aclk); while (master_smbus_tick !== 1'b1);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (master_smbus_tick !== 1'b1);
    check(n, cfg[1] ? SLOW : FAST);
    strap_cfg <= ~cfg;
    axi_wr(`SCG_OFF_STRAP, 32'h0, r);
    check(r, `SCG_RESP_OKAY);
    repeat (6) @(posedge aclk);
    check(master_smbus_slow, cfg[1]);
    check(port_width[0], exp_w(cfg[4], 1'b0));
    axi_rd(`SCG_OFF_STRAP, d, r);
    check(d, {24'h0, 1'b1, cfg});
    $display("Test straps %h done", cfg);
  endtask : t_straps

  // Reset values and an unmapped address.
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    foreach (RA[i])
    begin
      axi_rd(RA[i], d, r);
      check(d, (i == 3) ? 32'(`SCG_DSR_RST) : 32'h0);
    end
    axi_rd(8'h1c, d, r);
    check(r, `SCG_RESP_SLVERR);
    axi_wr(8'h1c, 32'h1, r);
    check(r, `SCG_RESP_SLVERR);
    wstrb <= 4'h1;
    axi_wr(`SCG_OFF_DOUT, 32'h3fff, r);
    wstrb <= 4'hf;
    axi_rd(`SCG_OFF_DOUT, d, r);
    check(d, 32'h00ff);
    $display("Test registers done");
  endtask : t_regs

  // Plain GPIO use of all pins, expander lines ignored.
  task automatic t_gpio;
    logic [31:0] d;
    logic [1:0]  r;
    exp_n <= 9'h01f;
    axi_wr(`SCG_OFF_DOUT, 32'h2a5a, r);
    axi_wr(`SCG_OFF_DOE, 32'h18ff, r);
    repeat (4) @(posedge aclk);
    check(gpio_oe, 14'h18ff);
    check(gpio_o & gpio_oe, 14'h085a);
    check({expander_interrupt_in_high, expander_interrupt_in}, 9'h0);
    axi_rd(`SCG_OFF_GPIN, d, r);
    check(d, 32'h085a);
    $display("Test gpio done");
  endtask : t_gpio

  // Alternate functions: resets out, expander interrupts in.
  task automatic t_alt;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(`SCG_OFF_ALT, 32'hffff, r);
    check(r, `SCG_RESP_OKAY);
    axi_rd(`SCG_OFF_ALT, d, r);
    check(d, 32'h27ff);
    axi_wr(`SCG_OFF_DSR, 32'h5, r);
    exp_n <= 9'h0a5;
    repeat (6) @(posedge aclk);
    check(gpio_oe, 14'h1807);
    check({gpio_o[30:29], gpio_o[20:18]}, 5'b01010);
    check(expander_interrupt_in, 8'h5a);
    check(expander_interrupt_in_high, 1'b1);
    axi_rd(`SCG_OFF_XINT, d, r);
    check(d, 32'h15a);
    $display("Test alternate done");
  endtask : t_alt

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    $display("ERROR %0t: timeout", $time);
    results();
  end

  // Main sequence.
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    strap_cfg = 7'h0a;
    exp_n = 9'h1ff;
    num_errors = 0;
    n_tests = 0;
    @(posedge aclk);
    t_straps(7'h0a);
    t_regs();
    t_gpio();
    t_alt();
    t_straps(7'h55);
    results();
  end
endmodule : tb

`default_nettype wire
